// ==== common/isp_defs.svh ====
`ifndef ISP_DEFS_SVH
`define ISP_DEFS_SVH

// Mode select codes
`define ISP_MODE_MASTER     4'h8
`define ISP_MODE_FW_MASTER  4'hB
`define ISP_MODE_SLV7       4'h6
`define ISP_MODE_SLV10      4'h7
`define ISP_MODE_SLV7_SP    4'hE
`define ISP_MODE_SLV10_SP   4'hF

// Byte framing
`define ISP_ADDR10_PREFIX   5'h1E
`define ISP_LAST_BIT        4'h8
`define ISP_ACK_BIT         4'h9
`define ISP_CNT_ZERO        4'h0
`define ISP_CNT_ONE         4'h1

// Reset values
`define ISP_BYTE_RST        8'h00
`define ISP_CKP_RST         1'b1

`endif

// ==== common/isp_pkg.sv ====
package isp_pkg;

  typedef enum logic [1:0] {st_idle, st_rx, st_tx} isp_state_t;

  typedef enum logic [1:0] {kind_addr_hi, kind_addr_lo, kind_data} isp_kind_t;

  // Status flags seen by software
  typedef struct packed {
    logic data_not_addr;
    logic stop_seen;
    logic start_seen;
    logic read_dir;
    logic addr_update_flag;
    logic buffer_full_flag;
  } isp_status_t;

  // Open-drain pin drive
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } isp_pins_t;

endpackage

// ==== logic/isp_slave_port.sv ====
`timescale 1ns/1ps
`include "isp_defs.svh"

module isp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;

  wire push = in_valid && in_ready;
  wire pop = (count_reg != '0) && (!out_valid_reg || out_ready);

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : p + 1'b1;
  endfunction

  assign in_ready = count_reg != FULL_CNT;
  assign out_valid = out_valid_reg;
  assign out_data = out_data_reg;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop)
      begin
        rd_ptr_reg <= ptr_inc(rd_ptr_reg);
        out_data_reg <= mem[rd_ptr_reg];
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
      if (pop)
        out_valid_reg <= 1'b1;
      else if (out_ready)
        out_valid_reg <= 1'b0;
    end
  end
endmodule

module isp_slave_port
  import isp_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration
  input wire logic port_enable_bit,
  input wire logic [3:0] mode_select_field,
  input wire logic rx_stretch_enable,
  input wire logic [1:0] pin_direction_reg,
  // Software strobes
  input wire logic addr_wr,
  input wire logic [7:0] addr_wr_data,
  input wire logic tx_wr,
  input wire logic [7:0] tx_wr_data,
  input wire logic buf_rd,
  input wire logic ckp_set,
  input wire logic irq_clear,
  input wire logic ov_clear,
  // Received bytes
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data,
  // Status
  output isp_status_t port_status_reg,
  output logic overflow_flag,
  output logic port_irq_flag,
  output logic clock_release_bit,
  output logic [7:0] own_address_reg,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output isp_pins_t pins
);
  isp_state_t state_reg, state_next;
  isp_kind_t kind_reg, kind_next;
  isp_status_t stat_reg, stat_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sr_reg, sr_next;
  logic [7:0] buf_reg, buf_next;
  logic [7:0] addr_reg, addr_next;
  logic ov_reg, ov_next;
  logic irq_reg, irq_next;
  logic ckp_reg, ckp_next;
  logic ack_reg, ack_next;
  logic lo_ok_reg, lo_ok_next;
  isp_pins_t pins_reg, pins_next;
  logic scl_meta, scl_sync, scl_prev;
  logic sda_meta, sda_sync, sda_prev;
  logic fifo_ready;

  // Bus edges from synchronised pins
  wire scl_rise = scl_sync && !scl_prev;
  wire scl_fall = !scl_sync && scl_prev;
  wire bus_start = scl_sync && scl_prev && sda_prev && !sda_sync;
  wire bus_stop = scl_sync && scl_prev && !sda_prev && sda_sync;

  // Mode decode
  wire mode_s7 = mode_select_field == `ISP_MODE_SLV7;
  wire mode_s10 = mode_select_field == `ISP_MODE_SLV10;
  wire mode_s7sp = mode_select_field == `ISP_MODE_SLV7_SP;
  wire mode_s10sp = mode_select_field == `ISP_MODE_SLV10_SP;
  wire mode_mst = mode_select_field == `ISP_MODE_MASTER ||
                  mode_select_field == `ISP_MODE_FW_MASTER;
  wire ten_bit = mode_s10 || mode_s10sp;
  wire sp_irq = mode_s7sp || mode_s10sp;
  wire slave = mode_s7 || mode_s10 || mode_s7sp || mode_s10sp;
  // Master modes are recognised but leave the slave engine idle
  wire i2c_mode = slave || mode_mst;
  wire pins_input = &pin_direction_reg;
  wire active = port_enable_bit && slave;
  wire drive_ok = port_enable_bit && i2c_mode && pins_input;

  // Byte framing
  wire rx_eval = state_reg == st_rx && scl_fall && cnt_reg == `ISP_LAST_BIT;
  wire rx_end = state_reg == st_rx && scl_fall && cnt_reg == `ISP_ACK_BIT;
  wire tx_ack = state_reg == st_tx && scl_rise && cnt_reg == `ISP_LAST_BIT;
  wire tx_end = state_reg == st_tx && scl_fall && cnt_reg == `ISP_ACK_BIT;
  wire blocked = stat_reg.buffer_full_flag || ov_reg;
  wire rd_take = buf_rd && fifo_ready;

  // Address compare on bits 7:1; the low address byte compares all 8 bits
  wire hi_hit = sr_reg[7:1] == addr_reg[7:1] &&
                (!ten_bit || sr_reg[7:3] == `ISP_ADDR10_PREFIX) &&
                (!ten_bit || !sr_reg[0] || lo_ok_reg);
  wire byte_hit = kind_reg == kind_data ||
                  (kind_reg == kind_addr_lo && sr_reg == addr_reg) ||
                  (kind_reg == kind_addr_hi && hi_hit);
  wire tx_bit_low = state_next == st_tx && cnt_next < `ISP_LAST_BIT &&
                    (stat_next.buffer_full_flag || cnt_next != `ISP_CNT_ZERO)
                    && !sr_next[7];

  always_comb
  begin
    state_next = state_reg;
    kind_next = kind_reg;
    stat_next = stat_reg;
    cnt_next = cnt_reg;
    sr_next = sr_reg;
    buf_next = buf_reg;
    addr_next = addr_reg;
    ov_next = ov_reg;
    irq_next = irq_reg;
    ckp_next = ckp_reg;
    ack_next = ack_reg;
    lo_ok_next = lo_ok_reg;
    // Software side first so that hardware events win a same-cycle clear
    if (irq_clear)
      irq_next = 1'b0;
    if (ov_clear)
      ov_next = 1'b0;
    if (rd_take)
      stat_next.buffer_full_flag = 1'b0;
    if (ckp_set)
      ckp_next = 1'b1;
    if (addr_wr)
    begin
      addr_next = addr_wr_data;
      stat_next.addr_update_flag = 1'b0;
    end
    if (tx_wr)
    begin
      buf_next = tx_wr_data;
      sr_next = tx_wr_data;
      stat_next.buffer_full_flag = 1'b1;
    end
    if (!active)
    begin
      state_next = st_idle;
      stat_next.start_seen = 1'b0;
      stat_next.stop_seen = 1'b0;
      stat_next.addr_update_flag = 1'b0;
      ack_next = 1'b0;
      lo_ok_next = 1'b0;
      ckp_next = `ISP_CKP_RST;
    end
    else if (bus_start)
    begin
      state_next = st_rx;
      kind_next = kind_addr_hi;
      cnt_next = `ISP_CNT_ZERO;
      stat_next.start_seen = 1'b1;
      stat_next.stop_seen = 1'b0;
      ack_next = 1'b0;
      if (sp_irq)
        irq_next = 1'b1;
    end
    else if (bus_stop)
    begin
      state_next = st_idle;
      stat_next.stop_seen = 1'b1;
      stat_next.start_seen = 1'b0;
      lo_ok_next = 1'b0;
      ack_next = 1'b0;
      if (sp_irq)
        irq_next = 1'b1;
    end
    else
    begin
      unique case (state_reg)
        st_idle:
        begin
        end
        st_rx:
        begin
          if (scl_rise && cnt_reg < `ISP_LAST_BIT)
            sr_next = {sr_reg[6:0], sda_sync};
          if (scl_rise)
            cnt_next = cnt_reg + `ISP_CNT_ONE;
          if (rx_eval && !byte_hit)
            state_next = st_idle;
          else if (rx_eval && blocked)
          begin
            // Keep a same-cycle overflow clear unless this byte overflows
            ov_next = ov_next || stat_reg.buffer_full_flag;
          end
          else if (rx_eval)
          begin
            ack_next = 1'b1;
            buf_next = sr_reg;
            stat_next.buffer_full_flag = 1'b1;
            stat_next.data_not_addr = kind_reg == kind_data;
            if (kind_reg == kind_addr_hi)
              stat_next.read_dir = sr_reg[0];
          end
          if (rx_end)
          begin
            ack_next = 1'b0;
            cnt_next = `ISP_CNT_ZERO;
            irq_next = 1'b1;
            unique case (kind_reg)
              kind_addr_hi:
                if (stat_reg.read_dir)
                begin
                  state_next = st_tx;
                  ckp_next = 1'b0;
                  // Full stays set; idle shifter keeps SDA released
                  sr_next = '1;
                end
                else if (ten_bit)
                begin
                  stat_next.addr_update_flag = 1'b1;
                  kind_next = kind_addr_lo;
                end
                else
                  kind_next = kind_data;
              kind_addr_lo:
              begin
                stat_next.addr_update_flag = 1'b1;
                kind_next = kind_data;
                lo_ok_next = 1'b1;
              end
              kind_data:
                if (rx_stretch_enable && stat_next.buffer_full_flag)
                  ckp_next = 1'b0;
            endcase
          end
        end
        st_tx:
        begin
          if (scl_fall && cnt_reg < `ISP_LAST_BIT)
          begin
            sr_next = {sr_reg[6:0], 1'b1};
            cnt_next = cnt_reg + `ISP_CNT_ONE;
            stat_next.buffer_full_flag = 1'b0;
          end
          if (tx_ack && sda_sync)
          begin
            state_next = st_idle;
            stat_next = '0;
            lo_ok_next = 1'b0;
          end
          else if (tx_ack)
            cnt_next = `ISP_ACK_BIT;
          if (tx_end)
          begin
            irq_next = 1'b1;
            cnt_next = `ISP_CNT_ZERO;
            stat_next.data_not_addr = 1'b1;
            if (!stat_next.buffer_full_flag)
              ckp_next = 1'b0;
          end
        end
      endcase
    end
    // Clear release bit or pending address update holds SCL
    pins_next.scl_o = 1'b0;
    pins_next.sda_o = 1'b0;
    pins_next.scl_oe = drive_ok && active &&
                       (!ckp_next || stat_next.addr_update_flag);
    pins_next.sda_oe = drive_ok && active && (ack_next || tx_bit_low);
  end

  always_ff @(posedge clk)
  begin
    scl_meta <= scl_in;
    scl_sync <= scl_meta;
    scl_prev <= scl_sync;
    sda_meta <= sda_in;
    sda_sync <= sda_meta;
    sda_prev <= sda_sync;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_reg <= st_idle;
      kind_reg <= kind_addr_hi;
      stat_reg <= '0;
      cnt_reg <= `ISP_CNT_ZERO;
      sr_reg <= `ISP_BYTE_RST;
      buf_reg <= `ISP_BYTE_RST;
      addr_reg <= `ISP_BYTE_RST;
      ov_reg <= 1'b0;
      irq_reg <= 1'b0;
      ckp_reg <= `ISP_CKP_RST;
      ack_reg <= 1'b0;
      lo_ok_reg <= 1'b0;
      pins_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      stat_reg <= stat_next;
      cnt_reg <= cnt_next;
      sr_reg <= sr_next;
      buf_reg <= buf_next;
      addr_reg <= addr_next;
      ov_reg <= ov_next;
      irq_reg <= irq_next;
      ckp_reg <= ckp_next;
      ack_reg <= ack_next;
      lo_ok_reg <= lo_ok_next;
      pins_reg <= pins_next;
    end
  end

  // Reading the buffer moves the byte into the queue; a full queue
  // refuses the read so the flag stays set and the next byte is not acknowledged
  isp_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(buf_rd),
    .in_ready(fifo_ready),
    .in_data(buf_reg),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign port_status_reg = stat_reg;
  assign overflow_flag = ov_reg;
  assign port_irq_flag = irq_reg;
  assign clock_release_bit = ckp_reg;
  assign own_address_reg = addr_reg;
  assign pins = pins_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_accept;
    rx_eval && byte_hit && !blocked && active && !bus_start && !bus_stop;
  endsequence
  sequence s_refuse;
    rx_eval && byte_hit && blocked && active && !bus_start && !bus_stop;
  endsequence

  port_off_a: assert property (!port_enable_bit |=> !pins_reg.scl_oe && !pins_reg.sda_oe)
    else $error("pins driven while disabled");
  pin_dir_a: assert property (!pins_input |=> !pins_reg.sda_oe && !pins_reg.scl_oe && !pins_reg.sda_o)
    else $error("pins driven while not inputs");
  ack_drive_a: assert property (s_accept |=> pins_reg.sda_oe == drive_ok && stat_reg.buffer_full_flag && buf_reg == $past(sr_reg))
    else $error("accepted byte not acknowledged or loaded");
  refuse_keep_a: assert property (s_refuse |=> !ack_reg && $stable(buf_reg) && ov_reg == (($past(ov_reg) && !$past(ov_clear)) || $past(stat_reg.buffer_full_flag)))
    else $error("refused byte changed buffer or acked");
  ov_sticky_a: assert property (ov_reg && !ov_clear |=> ov_reg)
    else $error("overflow dropped without clear");
  irq_ninth_a: assert property (rx_end && active && !bus_start && !bus_stop |=> irq_reg && !ack_reg)
    else $error("no flag at ninth fall");
  rx_stretch_a: assert property (rx_end && active && !bus_start && !bus_stop && kind_reg == kind_data && rx_stretch_enable && !rd_take && stat_reg.buffer_full_flag |=> !ckp_reg ##0 (pins_reg.scl_oe == drive_ok))
    else $error("receive stretch missing");
  ua_hold_a: assert property (stat_reg.addr_update_flag && active && drive_ok && !addr_wr |=> pins_reg.scl_oe)
    else $error("SCL not held for address update");
  tx_nack_a: assert property (tx_ack && sda_sync && active && !bus_start && !bus_stop |=> state_reg == st_idle && stat_reg == '0)
    else $error("slave not reset on no-ack");
endmodule

// ==== bench/isp_master_model.sv ====
`timescale 1ns/1ps
module isp_master_model (
  // Bus lines as seen on the wire
  input wire logic scl_line,
  input wire logic sda_line,
  // Master drive, 1 releases the line to the pull-up
  output logic scl_drv,
  output logic sda_drv
);
  initial
  begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  // Slave may stretch; bounded so a stuck SCL cannot hang the run
  task automatic rise();
    int n;
    scl_drv = 1'b1;
    n = 0;
    while (!scl_line && n < 5000)
    begin
      #4;
      n++;
    end
  endtask

  task automatic start_cond();
    sda_drv = 1'b1;
    #40;
    rise();
    #40;
    sda_drv = 1'b0;
    #40;
    scl_drv = 1'b0;
    #40;
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    #40;
    rise();
    #40;
    sda_drv = 1'b1;
    #80;
  endtask

  // One SCL pulse: data set while low, line sampled mid-high
  task automatic pulse(input logic d, output logic q);
    sda_drv = d;
    #40;
    rise();
    #40;
    q = sda_line;
    #40;
    scl_drv = 1'b0;
    #40;
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic q;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], q);
    pulse(1'b1, q);
    ack = !q;
  endtask

  task automatic read_byte(input logic ack, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(1'b1, q);
      b[i] = q;
    end
    pulse(!ack, q);
  endtask
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/1ps
module tb;
  import isp_pkg::*;
  localparam int k_rd = 0;
  localparam int k_ckp = 1;
  localparam int k_irq = 2;
  localparam int k_ov = 3;
  localparam int k_adr = 4;
  localparam int k_txw = 5;
  logic clk, srst, port_enable_bit, rx_stretch_enable, rx_ready, rx_valid;
  logic [3:0] mode_select_field;
  logic [1:0] pin_direction_reg;
  logic addr_wr, tx_wr, buf_rd, ckp_set, irq_clear, ov_clear;
  logic [7:0] addr_wr_data, tx_wr_data, rx_data, own_address_reg, got, d1;
  logic overflow_flag, port_irq_flag, clock_release_bit;
  logic scl_drv, sda_drv, ack;
  isp_status_t port_status_reg;
  isp_pins_t pins;
  // Open-drain wire with pull-up
  wire scl_line = scl_drv & ~pins.scl_oe;
  wire sda_line = sda_drv & ~pins.sda_oe;
  int error_cnt = 0;
  int check_count = 0;
  int seed = 32'h9ce4;
  logic [7:0] exp_q[$];

  initial
    clk = 1'b0;
  always #2 clk = ~clk;

  isp_slave_port u_isp_slave_port (
    .clk(clk), .srst(srst), .port_enable_bit(port_enable_bit),
    .mode_select_field(mode_select_field),
    .rx_stretch_enable(rx_stretch_enable),
    .pin_direction_reg(pin_direction_reg), .addr_wr(addr_wr),
    .addr_wr_data(addr_wr_data), .tx_wr(tx_wr), .tx_wr_data(tx_wr_data),
    .buf_rd(buf_rd), .ckp_set(ckp_set), .irq_clear(irq_clear),
    .ov_clear(ov_clear), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .port_status_reg(port_status_reg),
    .overflow_flag(overflow_flag), .port_irq_flag(port_irq_flag),
    .clock_release_bit(clock_release_bit),
    .own_address_reg(own_address_reg), .scl_in(scl_line),
    .sda_in(sda_line), .pins(pins)
  );

  isp_master_model u_isp_master_model (
    .scl_line(scl_line), .sda_line(sda_line),
    .scl_drv(scl_drv), .sda_drv(sda_drv)
  );

  task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic check_flag(input logic g, input logic e);
    check_byte({7'h00, g}, {7'h00, e});
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Software strobe, one cycle wide
  task automatic strobe(input int k, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr_wr_data = d;
    tx_wr_data = d;
    buf_rd = k == k_rd;
    ckp_set = k == k_ckp;
    irq_clear = k == k_irq;
    ov_clear = k == k_ov;
    addr_wr = k == k_adr;
    tx_wr = k == k_txw;
    @(posedge clk);
    #1;
    {addr_wr, tx_wr, buf_rd, ckp_set, irq_clear, ov_clear} = 6'h00;
  endtask

  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    u_isp_master_model.write_byte(b, ack);
    check_flag(ack, exp_ack);
  endtask

  // Drain side stalls at random
  always @(posedge clk)
  begin
    #1;
    rx_ready = 1'($random(seed));
  end

  // Scoreboard: oldest expected byte against each drained byte
  always @(posedge clk)
    if (!srst && rx_valid === 1'b1 && rx_ready === 1'b1)
    begin
      if (exp_q.size() == 0)
        check_flag(1'b0, 1'b1);
      else
        check_byte(rx_data, exp_q.pop_front());
    end

  initial
  begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    {srst, port_enable_bit, rx_stretch_enable, rx_ready} = 4'h8;
    {addr_wr, tx_wr, buf_rd, ckp_set, irq_clear, ov_clear} = 6'h00;
    {addr_wr_data, tx_wr_data} = 16'h0000;
    mode_select_field = 4'h6;
    pin_direction_reg = 2'h3;
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check_flag(clock_release_bit, 1'b1);
    check_flag(pins.scl_oe | pins.sda_oe | pins.scl_o | pins.sda_o, 1'b0);
    port_enable_bit = 1'b1;
    strobe(k_adr, 8'hA4);
    check_byte(own_address_reg, 8'hA4);
    // Disabled, master modes, pins not inputs: all stay silent
    for (int i = 0; i < 4; i++)
    begin
      port_enable_bit = (i != 0);
      mode_select_field = (i == 1) ? 4'h8 : (i == 2) ? 4'hB : 4'h6;
      pin_direction_reg = (i == 3) ? 2'($random(seed)) & 2'h2 : 2'h3;
      u_isp_master_model.start_cond();
      xfer(8'hA4, 1'b0);
      u_isp_master_model.stop_cond();
      // Pins not inputs: engine still matches, only the drive is cut
      check_flag(port_irq_flag, i == 3);
      if (i == 3)
      begin
        exp_q.push_back(8'hA4);
        strobe(k_rd, 8'h00);
        strobe(k_irq, 8'h00);
      end
    end
    pin_direction_reg = 2'h3;
    u_isp_master_model.start_cond();
    xfer(8'h52, 1'b0);
    u_isp_master_model.start_cond();
    xfer(8'hA4, 1'b1);
    check_flag(port_irq_flag, 1'b1);
    check_flag(port_status_reg.buffer_full_flag, 1'b1);
    check_flag(port_status_reg.read_dir, 1'b0);
    exp_q.push_back(8'hA4);
    strobe(k_rd, 8'h00);
    check_flag(port_status_reg.buffer_full_flag, 1'b0);
    strobe(k_irq, 8'h00);
    d1 = 8'($random(seed));
    xfer(d1, 1'b1);
    check_flag(port_status_reg.data_not_addr, 1'b1);
    strobe(k_irq, 8'h00);
    xfer(8'($random(seed)), 1'b0);
    check_flag(overflow_flag, 1'b1);
    check_flag(port_irq_flag, 1'b1);
    exp_q.push_back(d1);
    strobe(k_rd, 8'h00);
    check_flag(overflow_flag, 1'b1);
    strobe(k_ov, 8'h00);
    check_flag(overflow_flag, 1'b0);
    // Slave transmit: acked byte then refused byte
    u_isp_master_model.start_cond();
    xfer(8'hA5, 1'b1);
    check_flag(port_status_reg.read_dir, 1'b1);
    check_flag(pins.scl_oe, 1'b1);
    exp_q.push_back(8'hA5);
    strobe(k_rd, 8'h00);
    strobe(k_irq, 8'h00);
    for (int i = 0; i < 2; i++)
    begin
      d1 = 8'($random(seed));
      strobe(k_txw, d1);
      strobe(k_ckp, 8'h00);
      u_isp_master_model.read_byte(i == 0, got);
      check_byte(got, d1);
      if (i == 0)
      begin
        check_flag(port_irq_flag & ~clock_release_bit, 1'b1);
        strobe(k_irq, 8'h00);
      end
      else
        check_flag(port_status_reg.read_dir, 1'b0);
    end
    u_isp_master_model.stop_cond();
    // Receive stretch
    rx_stretch_enable = 1'b1;
    u_isp_master_model.start_cond();
    xfer(8'hA4, 1'b1);
    exp_q.push_back(8'hA4);
    strobe(k_rd, 8'h00);
    strobe(k_ckp, 8'h00);
    d1 = 8'($random(seed));
    xfer(d1, 1'b1);
    check_flag(pins.scl_oe & ~clock_release_bit, 1'b1);
    exp_q.push_back(d1);
    strobe(k_rd, 8'h00);
    strobe(k_ckp, 8'h00);
    check_flag(clock_release_bit, 1'b1);
    u_isp_master_model.stop_cond();
    rx_stretch_enable = 1'b0;
    // Start and stop flags in the modes that ask for them
    for (int i = 0; i < 2; i++)
    begin
      mode_select_field = i ? 4'hF : 4'hE;
      rx_stretch_enable = 1'($random(seed));
      strobe(k_irq, 8'h00);
      u_isp_master_model.start_cond();
      check_flag(port_status_reg.start_seen & port_irq_flag, 1'b1);
      u_isp_master_model.stop_cond();
      check_flag(port_status_reg.stop_seen, 1'b1);
    end
    // Ten-bit addressing, write then read
    mode_select_field = 4'h7;
    strobe(k_irq, 8'h00);
    strobe(k_adr, 8'hF2);
    u_isp_master_model.start_cond();
    xfer(8'hF2, 1'b1);
    check_flag(port_status_reg.addr_update_flag & pins.scl_oe, 1'b1);
    exp_q.push_back(8'hF2);
    strobe(k_rd, 8'h00);
    strobe(k_adr, 8'h34);
    check_flag(port_status_reg.addr_update_flag, 1'b0);
    xfer(8'h34, 1'b1);
    check_flag(port_status_reg.addr_update_flag, 1'b1);
    exp_q.push_back(8'h34);
    strobe(k_rd, 8'h00);
    strobe(k_adr, 8'hF2);
    check_flag(port_status_reg.addr_update_flag, 1'b0);
    u_isp_master_model.start_cond();
    xfer(8'hF3, 1'b1);
    check_flag(port_status_reg.addr_update_flag, 1'b0);
    check_flag(port_status_reg.buffer_full_flag, 1'b1);
    exp_q.push_back(8'hF3);
    strobe(k_rd, 8'h00);
    strobe(k_txw, 8'h5A);
    strobe(k_ckp, 8'h00);
    u_isp_master_model.read_byte(1'b0, got);
    check_byte(got, 8'h5A);
    u_isp_master_model.stop_cond();
    repeat (400) if (exp_q.size() != 0) @(posedge clk);
    check_flag(exp_q.size() == 0, 1'b1);
    end_of_test();
  end
endmodule
